//--- bench/tmop_stage_model.sv
// power stage model: one half bridge per complementary output pair
`default_nettype none
module tmop_stage_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // gate drives of one pair
  input wire logic hi,
  input wire logic hi_oe,
  input wire logic lo,
  input wire logic lo_oe,
  // sticky shoot-through flag
  output logic shoot
);
  // both switches on at once shorts the supply rail
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shoot <= 1'b0;
    end else if (hi && hi_oe && lo && lo_oe) begin
      shoot <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- bench/tmop_top_tb.sv
// self-checking bench for the output protection block
`default_nettype none
module tmop_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [15:0] cnt = 16'h0;
  logic [15:0] cnt_set = 16'h0;
  logic cnt_en = 1'b0;
  logic upd = 1'b0;
  logic [1:0] divv = 2'h0;
  logic [1:0] m2 = 2'h0;
  logic [1:0] m3 = 2'h0;
  // {idle_n, idle, comp_en, out_en, shadow, capture}
  logic [5:0] c2 = 6'h0;
  logic [5:0] c3 = 6'h0;
  logic [3:0] brk = 4'h0;
  logic cmf = 1'b0;
  logic [31:0] rdata;
  logic o2, o2e, n2, n2e, o3, o3e, n3, n3e, moe, lk1, lk2, lk3, irq, shoot;
  logic [31:0] r;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int n_checks = 0;
  int k;
  int g;

  tmop_top uut (.CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .COUNTER(cnt), .UPDATE_EVT(upd), .CLOCK_DIV(divv),
    .CH2_MODE(m2), .CH2_CAPTURE(c2[0]), .CH2_SHADOW_EN(c2[1]), .CH2_OUT_EN(c2[2]),
    .CH2_COMP_EN(c2[3]), .CH2_IDLE_LEVEL(c2[4]), .CH2_IDLE_LEVEL_N(c2[5]),
    .CH3_MODE(m3), .CH3_CAPTURE(c3[0]), .CH3_SHADOW_EN(c3[1]), .CH3_OUT_EN(c3[2]),
    .CH3_COMP_EN(c3[3]), .CH3_IDLE_LEVEL(c3[4]), .CH3_IDLE_LEVEL_N(c3[5]),
    .BREAK_IN(brk), .CLOCK_MON_FAIL(cmf), .CH2_O(o2), .CH2_O_OE(o2e), .CH2_ON(n2),
    .CH2_ON_OE(n2e), .CH3_O(o3), .CH3_O_OE(o3e), .CH3_ON(n3), .CH3_ON_OE(n3e),
    .MAIN_OE(moe), .LOCK_BASIC(lk1), .LOCK_OFFSTATE(lk2), .LOCK_COMPARE(lk3), .IRQ(irq));

  tmop_stage_model stage (.clk(clk), .nrst(nrst), .hi(o2), .hi_oe(o2e), .lo(n2),
    .lo_oe(n2e), .shoot(shoot));

  always #50 clk = ~clk;

  // wrap well below 16 bits so the reference toggles often
  always @(posedge clk) begin
    if (cnt_en) begin
      cnt <= (cnt >= 16'h07ff) ? 16'h0 : cnt + 16'h1;
    end else begin
      cnt <= cnt_set;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
      err_count++;
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_q <= rd;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  // outputs are registered behind the gating, so let them settle first
  task automatic pins(input logic [1:0] e);
    tick(3);
    chk({30'h0, o2e, n2e}, {30'h0, e});
  endtask

  task automatic pulse_upd();
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
    tick(4);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    err_count++;
    stop_test();
  end

  initial begin
    void'($urandom(58164));
    tick(10);
    nrst <= 1'b1;
    tick(1);
    rd_reg(tmop_pkg::ADDR_CH2, 32'h0);
    rd_reg(tmop_pkg::ADDR_CH3, 32'h0);
    rd_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0);
    rd_reg(tmop_pkg::ADDR_STAT, 32'h0);
    rd_reg(tmop_pkg::ADDR_MASK, 32'h0);
    rd_reg(8'h48, 32'h0);
    r = $urandom;
    wr_reg(tmop_pkg::ADDR_CH2, {16'h0, r[15:0]});
    rd_reg(tmop_pkg::ADDR_CH2, {16'h0, r[15:0]});
    // capture on channel 3, then a write that must not land
    r = $urandom;
    m3 <= 2'h1;
    cnt_set <= r[15:0];
    tick(1);
    c3[0] <= 1'b1;
    tick(1);
    c3[0] <= 1'b0;
    wr_reg(tmop_pkg::ADDR_CH3, 32'h0000_1234);
    rd_reg(tmop_pkg::ADDR_CH3, {16'h0, r[15:0]});
    chk({31'h0, irq}, 32'h0);
    wr_reg(tmop_pkg::ADDR_MASK, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rd_reg(tmop_pkg::ADDR_STAT, 32'h4);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd_reg(tmop_pkg::ADDR_STAT, 32'h0);
    // lock level one on the first write, later writes partly frozen
    wr_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_f185);
    rd_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_f185);
    chk({30'h0, lk2, lk1}, 32'h1);
    c2 <= 6'h10;
    wr_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_0e3a);
    rd_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_7d85);
    pins(2'b11);
    chk({30'h0, o2, n2}, 32'h2);
    wr_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_7985);
    pins(2'b00);
    c2 <= 6'h14;
    wr_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_f985);
    pins(2'b11);
    wr_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_f185);
    pins(2'b10);
    m2 <= 2'h1;
    pins(2'b00);
    chk({28'h0, o3, o3e, n3, n3e}, 32'h0);
    m2 <= 2'h0;
    // break active high on one random pin
    brk <= 4'(4'h1 << $urandom_range(3, 0));
    tick(6);
    chk({31'h0, moe}, 32'h0);
    pulse_upd();
    chk({31'h0, moe}, 32'h0);
    brk <= 4'h0;
    tick(4);
    pulse_upd();
    chk({31'h0, moe}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd_reg(tmop_pkg::ADDR_STAT, 32'h9);
    // dead time 0x85 is 138 ticks of two, then four clocks; first tick may come early
    c2 <= 6'h1e;
    wr_reg(tmop_pkg::ADDR_CH2, 32'h0000_0400);
    pulse_upd();
    cnt_en <= 1'b1;
    for (int d = 1; d < 3; d++) begin
      divv <= 2'(d);
      k = 0;
      while (o2 !== 1'b1 && k < 3000) begin
        tick(1);
        k++;
      end
      while (o2 !== 1'b0 && k < 3000) begin
        tick(1);
        k++;
      end
      g = 0;
      while (n2 !== 1'b1 && g < 1200) begin
        tick(1);
        g++;
      end
      chk(32'(g > 276 * d - 2 * d && g <= 276 * d), 32'h1);
      chk({31'h0, shoot}, 32'h0);
    end
    cnt_en <= 1'b0;
    // second reset: break pins active low but ignored
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(1);
    wr_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_8b00);
    tick(6);
    chk({31'h0, moe}, 32'h1);
    chk({29'h0, lk3, lk2, lk1}, 32'h7);
    wr_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_0400);
    rd_reg(tmop_pkg::ADDR_WRITE_LOCK_LEVEL, 32'h0000_0b00);
    tick(2);
    stop_test();
  end
endmodule
`default_nettype wire

//--- src/tmop_deadtime.sv
// dead-time inserter for one complementary output pair
`default_nettype none
module tmop_deadtime (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // dead-time clock enable and delay
  input wire logic tick,
  input wire logic [tmop_pkg::DT_W-1:0] dt,
  // reference in, pair out
  input wire logic ref_in,
  output logic out_p,
  output logic out_n
);
  logic ref_q;
  logic [tmop_pkg::DT_W-1:0] cnt_q;

  // each edge of the reference restarts the gap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_q <= 1'b0;
      cnt_q <= '0;
    end else if (ref_in != ref_q) begin
      ref_q <= ref_in;
      cnt_q <= dt;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // both sides held low while the gap runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else begin
      out_p <= ref_q && cnt_q == '0;
      out_n <= !ref_q && cnt_q == '0;
    end
  end

  no_overlap_a: assert property (@(posedge clk) disable iff (!nrst) !(out_p && out_n))
    else $error("pair outputs active together");
endmodule
`default_nettype wire

//--- src/tmop_pkg.sv
// constants and helpers shared by the output protection block
`default_nettype none
package tmop_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CH2 = 8'h3c;
  localparam logic [7:0] ADDR_CH3 = 8'h40;
  localparam logic [7:0] ADDR_WRITE_LOCK_LEVEL = 8'h44;
  localparam logic [7:0] ADDR_STAT = 8'h80;
  localparam logic [7:0] ADDR_MASK = 8'h84;
  // protection register field positions
  localparam int MOE_BIT = 15;
  localparam int AOE_BIT = 14;
  localparam int BPOL_BIT = 13;
  localparam int BEN_BIT = 12;
  localparam int ROFF_BIT = 11;
  localparam int IOFF_BIT = 10;
  localparam int LOCK_LSB = 8;
  localparam int DT_LSB = 0;
  // reset values
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [7:0] DT_RST = 8'h00;
  localparam logic [1:0] LOCK_RST = 2'h0;
  localparam logic [3:0] STAT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // lock levels and channel mode
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_L2 = 2'h2;
  localparam logic [1:0] LOCK_L3 = 2'h3;
  localparam logic [1:0] MODE_OUT = 2'h0;
  // status bits
  localparam int ST_BREAK = 0;
  localparam int ST_CAP2 = 1;
  localparam int ST_CAP3 = 2;
  localparam int ST_AUTO = 3;
  localparam int DT_W = 10;

  // dead time in dead-time clock ticks
  function automatic logic [DT_W-1:0] dt_ticks(input logic [7:0] s);
    logic [DT_W-1:0] r;
    r = '0;
    if (!s[7]) begin
      r = {2'h0, s};
    end else if (!s[6]) begin
      r = {2'h0, 2'h1, s[5:0]} << 1;
    end else if (!s[5]) begin
      r = {5'h01, s[4:0]} << 3;
    end else begin
      r = {5'h01, s[4:0]} << 4;
    end
    return r;
  endfunction
endpackage
`default_nettype wire

//--- src/tmop_top.sv
// compare values, protection register and output gating of channels 2 and 3
//
// The plain strobed port was decided locally.
`default_nettype none
// Function
// - input mode: value holds last capture, read-only
// - output mode: compare, shadow loads on update
// - main enable set by write or auto update
// - main enable cleared by write or break
// - main enable gates output-mode enabled channels
// - auto enable sets main enable without break
// - break polarity bit selects active level
// - break enable gates break and clock fail
// - run off-state bit: disabled or off level
// - idle: off level if idle off-state bit or either channel enable set, else disabled
// - lock one freezes break, auto, dead time
// - lock two also freezes run and idle off-state bits
// - lock three also raises the compare-control lock output
// - lock field writable once after reset
// - dead time decoded from top setting bits
// - dead-time tick divided by clock division
module tmop_top (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // timer context
  input wire logic [15:0] COUNTER,
  input wire logic UPDATE_EVT,
  input wire logic [1:0] CLOCK_DIV,
  // channel 2 settings
  input wire logic [1:0] CH2_MODE,
  input wire logic CH2_CAPTURE,
  input wire logic CH2_SHADOW_EN,
  input wire logic CH2_OUT_EN,
  input wire logic CH2_COMP_EN,
  input wire logic CH2_IDLE_LEVEL,
  input wire logic CH2_IDLE_LEVEL_N,
  // channel 3 settings
  input wire logic [1:0] CH3_MODE,
  input wire logic CH3_CAPTURE,
  input wire logic CH3_SHADOW_EN,
  input wire logic CH3_OUT_EN,
  input wire logic CH3_COMP_EN,
  input wire logic CH3_IDLE_LEVEL,
  input wire logic CH3_IDLE_LEVEL_N,
  // fault pins
  input wire logic [3:0] BREAK_IN,
  input wire logic CLOCK_MON_FAIL,
  // channel pins
  output logic CH2_O,
  output logic CH2_O_OE,
  output logic CH2_ON,
  output logic CH2_ON_OE,
  output logic CH3_O,
  output logic CH3_O_OE,
  output logic CH3_ON,
  output logic CH3_ON_OE,
  // status toward the rest of the timer
  output logic MAIN_OE,
  output logic LOCK_BASIC,
  output logic LOCK_OFFSTATE,
  output logic LOCK_COMPARE,
  output logic IRQ
);
  logic [1:0] mode [2];
  logic [1:0] cap, shadow, en, nen, idle_lvl, idle_lvl_n;
  logic [15:0] val_q [2], act_q [2];
  logic [1:0] wr_val, out_mode, ref_lvl, dt_p, dt_n;
  logic moe_q, aoe_q, bpol_q, ben_q, roff_q, ioff_q, lock_once_q;
  logic [1:0] lock_q;
  logic [7:0] dt_q;
  logic [3:0] brk_s1_q, brk_s2_q;
  logic ckm_s1_q, ckm_s2_q;
  logic brk_hit, wr_write_lock_level;
  logic [1:0] div_q, div_lim;
  logic dt_tick;
  logic [3:0] stat_q, mask_q, stat_set;
  logic [1:0] o_d, oe_d, on_d, one_d;
  logic [1:0] o_q, oe_q, on_q, one_q;
  logic [31:0] rdata_q;

  assign mode[0] = CH2_MODE;
  assign mode[1] = CH3_MODE;
  assign cap = {CH3_CAPTURE, CH2_CAPTURE};
  assign shadow = {CH3_SHADOW_EN, CH2_SHADOW_EN};
  assign en = {CH3_OUT_EN, CH2_OUT_EN};
  assign nen = {CH3_COMP_EN, CH2_COMP_EN};
  assign idle_lvl = {CH3_IDLE_LEVEL, CH2_IDLE_LEVEL};
  assign idle_lvl_n = {CH3_IDLE_LEVEL_N, CH2_IDLE_LEVEL_N};
  assign wr_val = {WR && ADDR == tmop_pkg::ADDR_CH3, WR && ADDR == tmop_pkg::ADDR_CH2};
  assign wr_write_lock_level = WR && ADDR == tmop_pkg::ADDR_WRITE_LOCK_LEVEL;

  // compare/capture values
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      val_q[0] <= tmop_pkg::VAL_RST;
      val_q[1] <= tmop_pkg::VAL_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!out_mode[i]) begin
          if (cap[i]) begin
            val_q[i] <= COUNTER;
          end
        end else if (wr_val[i]) begin
          val_q[i] <= WDATA[15:0];
        end
      end
    end
  end

  // shadowed compare values load only on update
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      act_q[0] <= tmop_pkg::VAL_RST;
      act_q[1] <= tmop_pkg::VAL_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!shadow[i] || UPDATE_EVT) begin
          act_q[i] <= val_q[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      out_mode[i] = mode[i] == tmop_pkg::MODE_OUT;
      ref_lvl[i] = COUNTER < act_q[i];
    end
  end

  // fault pins are asynchronous
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      brk_s1_q <= 4'h0;
      brk_s2_q <= 4'h0;
      ckm_s1_q <= 1'b0;
      ckm_s2_q <= 1'b0;
    end else begin
      brk_s1_q <= BREAK_IN;
      brk_s2_q <= brk_s1_q;
      ckm_s1_q <= CLOCK_MON_FAIL;
      ckm_s2_q <= ckm_s1_q;
    end
  end

  assign brk_hit = ben_q && ((|(bpol_q ? brk_s2_q : ~brk_s2_q)) || ckm_s2_q);

  // main enable: break beats everything, auto set beats software clear
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      moe_q <= 1'b0;
    end else if (brk_hit) begin
      moe_q <= 1'b0;
    end else if (UPDATE_EVT && aoe_q) begin
      moe_q <= 1'b1;
    end else if (wr_write_lock_level) begin
      moe_q <= WDATA[tmop_pkg::MOE_BIT];
    end
  end

  // lock-protected fields
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      aoe_q <= 1'b0;
      bpol_q <= 1'b0;
      ben_q <= 1'b0;
      dt_q <= tmop_pkg::DT_RST;
    end else if (wr_write_lock_level && lock_q == tmop_pkg::LOCK_NONE) begin
      aoe_q <= WDATA[tmop_pkg::AOE_BIT];
      bpol_q <= WDATA[tmop_pkg::BPOL_BIT];
      ben_q <= WDATA[tmop_pkg::BEN_BIT];
      dt_q <= WDATA[tmop_pkg::DT_LSB +: 8];
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      roff_q <= 1'b0;
      ioff_q <= 1'b0;
    end else if (wr_write_lock_level && lock_q < tmop_pkg::LOCK_L2) begin
      roff_q <= WDATA[tmop_pkg::ROFF_BIT];
      ioff_q <= WDATA[tmop_pkg::IOFF_BIT];
    end
  end

  // any protection-register write spends the one lock write
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      lock_q <= tmop_pkg::LOCK_RST;
      lock_once_q <= 1'b0;
    end else if (wr_write_lock_level && !lock_once_q) begin
      lock_q <= WDATA[tmop_pkg::LOCK_LSB +: 2];
      lock_once_q <= 1'b1;
    end
  end
  assign LOCK_BASIC = lock_q != tmop_pkg::LOCK_NONE;
  assign LOCK_OFFSTATE = lock_q >= tmop_pkg::LOCK_L2;
  assign LOCK_COMPARE = lock_q == tmop_pkg::LOCK_L3;
  assign MAIN_OE = moe_q;
  // dead-time clock enable from the timer clock
  always_comb begin
    unique case (CLOCK_DIV)
      2'h0: div_lim = 2'h0;
      2'h1: div_lim = 2'h1;
      default: div_lim = 2'h3;
    endcase
  end
  assign dt_tick = div_q >= div_lim;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      div_q <= 2'h0;
    end else begin
      div_q <= dt_tick ? 2'h0 : div_q + 2'h1;
    end
  end
  for (genvar g = 0; g < 2; g++) begin : g_dt
    tmop_deadtime u_dt (
      .clk(CLK_SYS),
      .nrst(NRST),
      .tick(dt_tick),
      .dt(tmop_pkg::dt_ticks(dt_q)),
      .ref_in(ref_lvl[g]),
      .out_p(dt_p[g]),
      .out_n(dt_n[g])
    );
  end

  // output gating; off-state in run mode is the inactive level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      o_d[i] = 1'b0;
      oe_d[i] = 1'b0;
      on_d[i] = 1'b0;
      one_d[i] = 1'b0;
      if (out_mode[i]) begin
        if (moe_q) begin
          if (en[i]) begin
            oe_d[i] = 1'b1;
            o_d[i] = nen[i] ? dt_p[i] : ref_lvl[i];
          end else begin
            oe_d[i] = roff_q;
          end
          if (nen[i]) begin
            one_d[i] = 1'b1;
            on_d[i] = en[i] ? dt_n[i] : !ref_lvl[i];
          end else begin
            one_d[i] = roff_q;
          end
        end else if (ioff_q || en[i] || nen[i]) begin
          oe_d[i] = 1'b1;
          one_d[i] = 1'b1;
          o_d[i] = idle_lvl[i];
          on_d[i] = idle_lvl_n[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      o_q <= 2'h0;
      oe_q <= 2'h0;
      on_q <= 2'h0;
      one_q <= 2'h0;
    end else begin
      o_q <= o_d;
      oe_q <= oe_d;
      on_q <= on_d;
      one_q <= one_d;
    end
  end

  assign CH2_O = o_q[0];
  assign CH2_O_OE = oe_q[0];
  assign CH2_ON = on_q[0];
  assign CH2_ON_OE = one_q[0];
  assign CH3_O = o_q[1];
  assign CH3_O_OE = oe_q[1];
  assign CH3_ON = on_q[1];
  assign CH3_ON_OE = one_q[1];

  // sticky events, cleared by reading; a new event wins over the clear
  assign stat_set = {UPDATE_EVT && aoe_q && !brk_hit && !moe_q,
                     CH3_CAPTURE && !out_mode[1],
                     CH2_CAPTURE && !out_mode[0],
                     brk_hit};

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      stat_q <= tmop_pkg::STAT_RST;
    end else if (RD && ADDR == tmop_pkg::ADDR_STAT) begin
      stat_q <= stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      mask_q <= tmop_pkg::MASK_RST;
    end else if (WR && ADDR == tmop_pkg::ADDR_MASK) begin
      mask_q <= WDATA[3:0];
    end
  end
  assign IRQ = |(stat_q & mask_q);
  // read data valid the cycle after the strobe only
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rdata_q <= 32'h0;
    end else if (!RD) begin
      rdata_q <= 32'h0;
    end else begin
      unique case (ADDR)
        tmop_pkg::ADDR_CH2: rdata_q <= {16'h0, val_q[0]};
        tmop_pkg::ADDR_CH3: rdata_q <= {16'h0, val_q[1]};
        tmop_pkg::ADDR_WRITE_LOCK_LEVEL: rdata_q <= {16'h0, moe_q, aoe_q, bpol_q, ben_q,
                                        roff_q, ioff_q, lock_q, dt_q};
        tmop_pkg::ADDR_STAT: rdata_q <= {28'h0, stat_q};
        tmop_pkg::ADDR_MASK: rdata_q <= {28'h0, mask_q};
        default: rdata_q <= 32'h0;
      endcase
    end
  end
  assign RDATA = rdata_q;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  break_clears_a: assert property (brk_hit |=> !moe_q)
    else $error("main enable survived a break");
  auto_sets_a: assert property (UPDATE_EVT && aoe_q && !brk_hit |=> moe_q)
    else $error("auto enable did not set main enable");
  manual_only_a: assert property (!aoe_q && !wr_write_lock_level && !moe_q |=> !moe_q)
    else $error("main enable set without software");
  break_gated_a: assert property (!ben_q && moe_q && !(wr_write_lock_level && !WDATA[15])
    |=> moe_q)
    else $error("disabled break cleared main enable");
  lock_once_a: assert property (lock_once_q && wr_write_lock_level |=> $stable(lock_q))
    else $error("lock field written twice");
  lock_basic_a: assert property (lock_q != 2'h0 && wr_write_lock_level
    |=> $stable(dt_q) && $stable(ben_q) && $stable(aoe_q))
    else $error("locked field changed");
  lock_off_a: assert property (lock_q[1] && wr_write_lock_level |=> $stable(roff_q) && $stable(ioff_q))
    else $error("off-state bits changed under lock");
  capture_ro_a: assert property (!out_mode[1] && wr_val[1] && !cap[1]
    |=> $stable(val_q[1]))
    else $error("capture value written");
  shadow_hold_a: assert property (shadow[0] && !UPDATE_EVT |=> $stable(act_q[0]))
    else $error("shadow loaded without update");
  mode_gate_a: assert property (!out_mode[0] |=> !CH2_O_OE && !CH2_ON_OE)
    else $error("input-mode channel driven");
  run_off_a: assert property (out_mode[0] && moe_q && !nen[0] && roff_q
    |=> CH2_ON_OE && !CH2_ON)
    else $error("run off-state not driven");
  idle_off_a: assert property (out_mode[0] && !moe_q && ioff_q
    |=> CH2_O_OE && CH2_ON_OE)
    else $error("idle off-state not driven");
  break_seen_c: cover property (moe_q && brk_hit ##1 !moe_q);
  auto_seen_c: cover property (!moe_q && UPDATE_EVT && aoe_q ##1 moe_q);
  lock_seen_c: cover property (lock_q == 2'h3);
  gap_seen_c: cover property (CH2_O_OE && CH2_ON_OE && !CH2_O && !CH2_ON);
endmodule
`default_nettype wire
